// ### verilog/nibble_cpu_instruction_decode.sv
// instruction decode and execute core of the nibble cpu
// ==========================================================
// Overview of operation
// - nine-bit word: five column bits, four row
// - columns 10-17 call page 2; 18-1F branch
// - second words: jumps 11, call 10, fixed patterns
// - B/A and Y/A moves, carry untouched
// - E packs B high, A low; reverse
// - D takes low three accumulator bits
// - load X,Y immediates; consecutive loads skipped
// - increment Y, skip on zero
// - decrement Y, skip on fifteen
// - RAM to A, then X xor j
// - swap A with RAM, X xor j; rows 8-F also step Y
// - load A immediate; consecutive loads skipped
// - table read page p, D:A, bits to B,A
// - flag copies bit 8 to carry; stack used
// - add RAM; carry variant updates carry
// - add immediate, carry kept, skip no overflow
// - set/clear carry; skip when carry zero
// - accumulator becomes its complement
// - rotate carry and accumulator right
// - A combined with E by selected function
`timescale 1ns/1ps
`include "nibble_cpu_consts.svh"
module nibble_cpu_instruction_decode
  import nibble_cpu_pkg::*;
#(
  parameter int PC_W   = 11,
  parameter int DEPTH  = 4
) (
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  output logic [PC_W-1:0]      rom_addr,
  input  wire logic [8:0]      rom_data,
  output logic [5:0]           ram_addr,
  input  wire logic [3:0]      ram_rdata,
  output logic [3:0]           ram_wdata,
  output logic                 ram_we,
  output logic [3:0]           acc,
  output logic [3:0]           reg_b,
  output logic [7:0]           reg_e,
  output logic [2:0]           reg_d,
  output logic [1:0]           reg_x,
  output logic [3:0]           reg_y,
  output logic                 carry_bit,
  output logic [1:0]           bool_function_select,
  output logic                 upper_bit_fetch_flag,
  output logic [1:0]           stack_ptr,
  output logic                 skip_flag
);
  // ==========================================================
  // state
  exec_state_t          state;
  logic [PC_W-1:0]      pc;
  logic [PC_W-1:0]      stack [DEPTH];
  logic [8:0]           first_word;
  logic                 last_lxy;
  logic                 last_la;
  nibble_alu_if         alu ();

  nibble_adder u_adder (
    .bus (alu)
  );

  // ==========================================================
  // decode helpers
  function automatic logic [4:0] col_of(input logic [8:0] w);
    return w[`COL_HI:`COL_LO];
  endfunction

  // columns 10-1f (page-2 calls, in-page branches) stay single words
  function automatic logic two_word(input logic [8:0] w);
    return (w == `OP_BA) || (w == `OP_BLA) || (w == `OP_SZD) || (w == `OP_SEA) ||
           (col_of(w) == `COL_BL) || (col_of(w) == `COL_BML) ||
           (col_of(w) == `COL_BMLA && w[3:0] == 4'h0);
  endfunction

  function automatic logic [3:0] logic_fn(input logic [1:0] sel, input logic [3:0] a,
                                          input logic [3:0] e);
    unique case (bool_fn_t'(sel))
      LOG_XOR: return a ^ e;
      LOG_OR:  return a | e;
      LOG_AND: return a & e;
      LOG_RSV: return a;
    endcase
  endfunction

  logic [8:0]  iw;
  logic [4:0]  col;
  logic [5:0]  dp;
  logic [3:0]  y_inc;
  logic [3:0]  y_dec;
  logic        is_lxy;
  logic        is_la;
  logic        exec_ok;
  assign iw      = rom_data;
  assign col     = col_of(iw);
  assign dp      = {reg_x, reg_y};
  assign y_inc   = reg_y + 4'h1;
  assign y_dec   = reg_y - 4'h1;
  assign is_lxy  = (iw[8:6] == 3'b011);
  assign is_la   = (col == `COL_LA);
  // repeated immediate loads are suppressed like a skip
  assign exec_ok = (state == ST_EXEC) && !skip_flag
                   && !(is_lxy && last_lxy) && !(is_la && last_la);

  // adder operands: memory add, carry add, or immediate add
  always_comb begin
    alu.op_a = acc;
    alu.op_b = (col == `COL_ADDI) ? iw[3:0] : ram_rdata;
    alu.cin  = (iw == `OP_AMC) ? carry_bit : 1'b0;
  end

  // ==========================================================
  // sequencing: pc, state, stack for the table read
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state      <= ST_EXEC;
      pc         <= '0;
      first_word <= 9'h000;
      stack_ptr  <= 2'h0;
      for (int i = 0; i < DEPTH; i++) begin
        stack[i] <= '0;
      end
    end else begin
      unique case (state)
        ST_EXEC: begin
          pc <= pc + PC_W'(1);
          if (exec_ok && col == `COL_ROM_TABLE_LOOKUP) begin
            // return address occupies one level during the read
            stack[stack_ptr] <= pc + PC_W'(1);
            stack_ptr        <= stack_ptr + 2'h1;
            pc               <= {iw[3:0], reg_d, acc};
            state            <= ST_TBL1;
          end else if (exec_ok && two_word(iw)) begin
            first_word <= iw;
            state      <= ST_WORD2;
          end
        end
        ST_TBL1: state <= ST_TBL2;
        ST_TBL2: begin
          pc        <= stack[stack_ptr - 2'h1];
          stack_ptr <= stack_ptr - 2'h1;
          state     <= ST_EXEC;
        end
        ST_WORD2: begin
          // branch second words carry the target; control flow is out of scope
          pc    <= pc + PC_W'(1);
          state <= ST_EXEC;
        end
      endcase
    end
  end

  assign rom_addr = pc;

  // ==========================================================
  // skip generation
  logic next_skip;
  always_comb begin
    next_skip = 1'b0;
    if (state == ST_WORD2) begin
      // immediate compare lives in the second word
      if (first_word == `OP_SEA && iw[8:4] == `W2_SEA) begin
        next_skip = (acc == iw[3:0]);
      end
    end else if (state == ST_EXEC && exec_ok) begin
      if (iw == `OP_INY) next_skip = (y_inc == 4'h0);
      if (iw == `OP_DEY) next_skip = (y_dec == 4'hf);
      if (col == `COL_XAM && iw[3:2] == 2'b10) next_skip = (y_inc == 4'h0);
      if (col == `COL_XAM && iw[3:2] == 2'b11) next_skip = (y_dec == 4'hf);
      if (col == `COL_ADDI) next_skip = !alu.cout;
      if (iw == `OP_SZC) next_skip = !carry_bit;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      skip_flag <= 1'b0;
    end else if (state == ST_EXEC || state == ST_WORD2) begin
      skip_flag <= next_skip;
    end
  end

  // run tracking for the consecutive-load suppression
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      last_lxy <= 1'b0;
      last_la  <= 1'b0;
    end else if (state == ST_EXEC) begin
      last_lxy <= is_lxy;
      last_la  <= is_la;
    end else begin
      last_lxy <= 1'b0;
      last_la  <= 1'b0;
    end
  end

  // ==========================================================
  // accumulator and B
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc   <= `RST_NIB;
      reg_b <= `RST_NIB;
    end else if (state == ST_TBL2) begin
      reg_b <= rom_data[7:4];
      acc   <= rom_data[3:0];
    end else if (exec_ok) begin
      if (iw == `OP_TAB) acc <= reg_b;
      if (iw == `OP_TBA) reg_b <= acc;
      if (iw == `OP_TAY) acc <= reg_y;
      if (iw == `OP_UNPACK_E_INTO_AB) begin
        reg_b <= reg_e[7:4];
        acc   <= reg_e[3:0];
      end
      if (col == `COL_XAM) acc <= ram_rdata;
      if (is_la) acc <= iw[3:0];
      if (iw == `OP_AM || iw == `OP_AMC || col == `COL_ADDI) begin
        acc <= alu.sum;
      end
      if (iw == `OP_CMA) acc <= ~acc;
      if (iw == `OP_RAR) acc <= {carry_bit, acc[3:1]};
      if (iw == `OP_BOOL_OP_EXEC) acc <= logic_fn(bool_function_select, acc, reg_e[3:0]);
    end
  end

  // ==========================================================
  // carry
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      carry_bit <= 1'b0;
    end else if (state == ST_TBL2) begin
      if (upper_bit_fetch_flag) carry_bit <= rom_data[8];
    end else if (exec_ok) begin
      if (iw == `OP_AMC) carry_bit <= alu.cout;
      if (iw == `OP_SC) carry_bit <= 1'b1;
      if (iw == `OP_RC) carry_bit <= 1'b0;
      if (iw == `OP_RAR) carry_bit <= acc[0];
    end
  end

  // ==========================================================
  // E, D, logic select, fetch flag
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_e                <= 8'h00;
      reg_d                <= 3'h0;
      bool_function_select <= 2'h0;
      upper_bit_fetch_flag <= 1'b0;
    end else if (exec_ok) begin
      if (iw == `OP_PACK_AB_INTO_E) reg_e <= {reg_b, acc};
      if (iw == `OP_TDA) reg_d <= acc[2:0];
      if (iw == `OP_TLOA) bool_function_select <= acc[1:0];
      if (iw == `OP_URSC) upper_bit_fetch_flag <= 1'b1;
    end
  end

  // ==========================================================
  // data pointer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_x <= 2'h0;
      reg_y <= `RST_NIB;
    end else if (exec_ok) begin
      if (is_lxy) begin
        reg_x <= iw[5:4];
        reg_y <= iw[3:0];
      end
      if (iw == `OP_TYA) reg_y <= acc;
      if (iw == `OP_INY) reg_y <= y_inc;
      if (iw == `OP_DEY) reg_y <= y_dec;
      if (col == `COL_XAM) begin
        reg_x <= reg_x ^ iw[1:0];
        if (iw[3:2] == 2'b10) reg_y <= y_inc;
        if (iw[3:2] == 2'b11) reg_y <= y_dec;
      end
    end
  end

  // ==========================================================
  // ram port: address follows the pointer, writes for the swaps
  assign ram_addr = dp;
  always_comb begin
    ram_wdata = acc;
    ram_we    = exec_ok && col == `COL_XAM && iw[3:2] != 2'b01;
  end
endmodule

// ### verilog/nibble_cpu_consts.svh
// constants for the nibble cpu instruction decoder
`ifndef NIBBLE_CPU_CONSTS_SVH
`define NIBBLE_CPU_CONSTS_SVH
// ==========================================================
// opcode map fields
`define COL_HI        8
`define COL_LO        4
`define ROW_HI        3
// ==========================================================
// first words of single-word instructions
`define OP_NOP        9'h000
`define OP_AM         9'h00a
`define OP_AMC        9'h00b
`define OP_TYA        9'h00c
`define OP_TBA        9'h00e
`define OP_RC         9'h006
`define OP_SC         9'h007
`define OP_INY        9'h013
`define OP_DEY        9'h017
`define OP_PACK_AB_INTO_E       9'h01a
`define OP_CMA        9'h01c
`define OP_RAR        9'h01d
`define OP_TAB        9'h01e
`define OP_TAY        9'h01f
`define OP_TDA        9'h029
`define OP_UNPACK_E_INTO_AB       9'h02a
`define OP_SZC        9'h02f
`define OP_BOOL_OP_EXEC       9'h041
`define OP_TLOA       9'h058
`define OP_URSC       9'h082
// two-word first words
`define OP_BA         9'h001
`define OP_BLA        9'h010
`define OP_SZD        9'h024
`define OP_SEA        9'h025
// ==========================================================
// columns (upper five bits)
`define COL_BL        5'h03
`define COL_BMLA      5'h05
`define COL_XAM       5'h06
`define COL_BML       5'h07
`define COL_ROM_TABLE_LOOKUP      5'h09
`define COL_ADDI      5'h0a
`define COL_LA        5'h0b
// second-word prefixes
`define W2_JUMP       2'h3
`define W2_CALL       2'h2
`define W2_SEA        5'h0b
`define W2_SZD        9'h02b
// reset values
`define RST_NIB       4'h0
`endif

// ### verilog/nibble_cpu_pkg.sv
// types shared by the nibble cpu decoder files
package nibble_cpu_pkg;
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,
    ST_TBL1  = 2'b01,
    ST_TBL2  = 2'b10,
    ST_WORD2 = 2'b11
  } exec_state_t;
  typedef enum logic [1:0] {
    LOG_XOR = 2'b00,
    LOG_OR  = 2'b01,
    LOG_AND = 2'b10,
    LOG_RSV = 2'b11
  } bool_fn_t;
endpackage

// ### verilog/nibble_alu_if.sv
// carrier between the decoder and its nibble adder
`timescale 1ns/1ps
interface nibble_alu_if;
  logic [3:0] op_a;
  logic [3:0] op_b;
  logic       cin;
  logic [3:0] sum;
  logic       cout;
  modport user (output op_a, output op_b, output cin, input sum, input cout);
  modport alu  (input op_a, input op_b, input cin, output sum, output cout);
endinterface

// ### verilog/nibble_adder.sv
// four-bit adder with carry in and carry out
`timescale 1ns/1ps
module nibble_adder (
  nibble_alu_if.alu bus
);
  logic [4:0] full;
  assign full     = {1'b0, bus.op_a} + {1'b0, bus.op_b} + {4'h0, bus.cin};
  assign bus.sum  = full[3:0];
  assign bus.cout = full[4];
endmodule

// ### testbench/nibble_mem_model.sv
// program rom and data ram facing the decoder
`timescale 1ns/1ps
module nibble_mem_model #(
  parameter int PC_W = 11
) (
  input  logic            sys_clk,
  input  logic [PC_W-1:0] rom_addr,
  output logic [8:0]      rom_data,
  input  logic [5:0]      ram_addr,
  output logic [3:0]      ram_rdata,
  input  logic [3:0]      ram_wdata,
  input  logic            ram_we
);
  logic [8:0] rom [0:(1<<PC_W)-1];
  logic [3:0] ram [0:63];
  // ==========================================================
  // combinational reads, write on the clock edge
  assign rom_data  = rom[rom_addr];
  assign ram_rdata = ram[ram_addr];
  // plain always: the bench preloads ram between tests from its own process
  always @(posedge sys_clk) begin
    if (ram_we) begin
      ram[ram_addr] <= ram_wdata;
    end
  end
endmodule

// ### testbench/nibble_cpu_checker.sv
// port-level assertions for the instruction decoder
`timescale 1ns/1ps
`include "nibble_cpu_consts.svh"
module nibble_cpu_checker (
  input logic       sys_clk,
  input logic       resetn,
  input logic [8:0] rom_data,
  input logic [5:0] ram_addr,
  input logic       ram_we,
  input logic [3:0] acc,
  input logic [3:0] reg_b,
  input logic [7:0] reg_e,
  input logic [2:0] reg_d,
  input logic [1:0] reg_x,
  input logic [3:0] reg_y,
  input logic       carry_bit,
  input logic       skip_flag
);
  // ==========================================================
  // track cycles whose rom word is data, not an opcode
  logic [1:0] hold;
  logic       ex;
  logic       two;
  assign ex  = (hold == 2'h0) && !skip_flag;
  assign two = rom_data[8:4] == 5'h03 || rom_data[8:4] == 5'h07 || rom_data == `OP_BA ||
               rom_data == `OP_BLA || rom_data == `OP_SZD || rom_data == `OP_SEA ||
               rom_data == 9'h050;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hold <= 2'h0;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else if (!skip_flag && rom_data[8:4] == `COL_ROM_TABLE_LOOKUP) begin
      hold <= 2'h2;
    end else if (!skip_flag && two) begin
      hold <= 2'h1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // assertions
  property p_move_b;
    ex && rom_data == `OP_TBA |=> reg_b == $past(acc) && $stable(carry_bit);
  endproperty
  a_move_b: assert property (p_move_b) else $error("a to b move wrong");
  property p_move_y;
    ex && rom_data == `OP_TAY |=> acc == $past(reg_y);
  endproperty
  a_move_y: assert property (p_move_y) else $error("y to a move wrong");
  property p_pack;
    ex && rom_data == `OP_PACK_AB_INTO_E |=> reg_e == {$past(reg_b), $past(acc)};
  endproperty
  a_pack: assert property (p_pack) else $error("e pack wrong");
  property p_to_d;
    ex && rom_data == `OP_TDA |=> reg_d == $past(acc[2:0]);
  endproperty
  a_to_d: assert property (p_to_d) else $error("d load wrong");
  property p_inc_y;
    ex && rom_data == `OP_INY |=> reg_y == $past(reg_y) + 4'h1 && skip_flag == (reg_y == 4'h0);
  endproperty
  a_inc_y: assert property (p_inc_y) else $error("y increment wrong");
  property p_dec_y;
    ex && rom_data == `OP_DEY |=> reg_y == $past(reg_y) - 4'h1 && skip_flag == (reg_y == 4'hf);
  endproperty
  a_dec_y: assert property (p_dec_y) else $error("y decrement wrong");
  property p_carry_set;
    ex && (rom_data == `OP_SC || rom_data == `OP_RC) |=> carry_bit == $past(rom_data[0]);
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("carry force wrong");
  property p_invert;
    ex && rom_data == `OP_CMA |=> acc == ~$past(acc);
  endproperty
  a_invert: assert property (p_invert) else $error("complement wrong");
  property p_pointer;
    ram_addr == {reg_x, reg_y};
  endproperty
  a_pointer: assert property (p_pointer) else $error("ram address wrong");
  property p_swap_we;
    ex && rom_data[8:4] == `COL_XAM |-> ram_we == (rom_data[3:2] != 2'b01);
  endproperty
  a_swap_we: assert property (p_swap_we) else $error("ram write strobe wrong");
  property p_skip_nop;
    skip_flag && hold == 2'h0 |-> !ram_we ##1 $stable(acc) && $stable(carry_bit);
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skipped word acted");
endmodule
bind nibble_cpu_instruction_decode nibble_cpu_checker chk_u (.sys_clk(sys_clk),
  .resetn(resetn), .rom_data(rom_data), .ram_addr(ram_addr), .ram_we(ram_we), .acc(acc),
  .reg_b(reg_b), .reg_e(reg_e), .reg_d(reg_d), .reg_x(reg_x), .reg_y(reg_y),
  .carry_bit(carry_bit), .skip_flag(skip_flag));

// ### testbench/tb_top.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module tb_top;
  import nibble_cpu_pkg::*;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [10:0] rom_addr;
  logic [8:0]  rom_data;
  logic [5:0]  ram_addr;
  logic [3:0]  ram_rdata, ram_wdata, acc, reg_b, reg_y;
  logic        ram_we, carry_bit, upper_bit_fetch_flag, skip_flag;
  logic [7:0]  reg_e;
  logic [2:0]  reg_d;
  logic [1:0]  reg_x, bool_function_select, stack_ptr;
  int          miscompares = 0;
  int          checked = 0;
  always #12.5 sys_clk = ~sys_clk;
  nibble_cpu_instruction_decode dut_u (.sys_clk(sys_clk), .resetn(resetn),
    .rom_addr(rom_addr), .rom_data(rom_data), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
    .ram_wdata(ram_wdata), .ram_we(ram_we), .acc(acc), .reg_b(reg_b), .reg_e(reg_e),
    .reg_d(reg_d), .reg_x(reg_x), .reg_y(reg_y), .carry_bit(carry_bit),
    .bool_function_select(bool_function_select), .upper_bit_fetch_flag(upper_bit_fetch_flag),
    .stack_ptr(stack_ptr), .skip_flag(skip_flag));
  nibble_mem_model mem_u (.sys_clk(sys_clk), .rom_addr(rom_addr), .rom_data(rom_data),
    .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_wdata(ram_wdata), .ram_we(ram_we));
  // ==========================================================
  // helpers
  task chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  // eight words from pc 0 up, rest of rom left as no-ops
  task prog(input logic [71:0] w);
    @(posedge sys_clk);
    resetn <= 1'b0;
    for (int i = 0; i < 2048; i++) mem_u.rom[i] = 9'h000;
    for (int i = 0; i < 64; i++) mem_u.ram[i] = 4'h0;
    for (int i = 0; i < 8; i++) mem_u.rom[i] = w[71-9*i -: 9];
  endtask
  task go(input int n);
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // ==========================================================
  // scenarios
  task t_moves;
    prog({9'h0b5, 9'h00e, 9'h01c, 9'h01a, 9'h0b3, 9'h0b4, 9'h029, 9'h041});
    go(8);
    chk("b", 9'h005, reg_b);
    chk("e", 9'h05a, reg_e);
    chk("d", 9'h003, reg_d);
    chk("fn", 9'h000, bool_function_select);
    chk("acc", 9'h009, acc);
    $display("test moves done");
  endtask
  task t_pointer;
    prog({9'h0cf, 9'h0c3, 9'h013, 9'h0b7, 9'h017, 9'h0b9, 9'h01f, 9'h000});
    go(7);
    chk("x", 9'h000, reg_x);
    chk("y", 9'h00f, reg_y);
    chk("acc", 9'h00f, acc);
    $display("test pointer done");
  endtask
  task t_ram;
    prog({9'h0d2, 9'h0b1, 9'h00a, 9'h007, 9'h00b, 9'h065, 9'h06c, 9'h000});
    mem_u.ram[6'h12] = 4'ha;
    mem_u.ram[6'h02] = 4'h9;
    go(7);
    chk("carry", 9'h001, carry_bit);
    chk("x", 9'h000, reg_x);
    chk("acc", 9'h009, acc);
    chk("ram", 9'h00a, mem_u.ram[6'h02]);
    chk("y", 9'h001, reg_y);
    chk("ram_addr", 9'h001, ram_addr);
    $display("test ram done");
  endtask
  task t_arith;
    prog({9'h007, 9'h0b9, 9'h0a3, 9'h006, 9'h0a8, 9'h01d, 9'h02f, 9'h007});
    go(8);
    chk("acc", 9'h00a, acc);
    chk("carry", 9'h000, carry_bit);
    $display("test arith done");
  endtask
  task t_table;
    prog({9'h0b5, 9'h029, 9'h0b3, 9'h082, 9'h092, 9'h000, 9'h000, 9'h000});
    mem_u.rom[11'h153] = 9'h1c7;
    go(8);
    chk("b", 9'h00c, reg_b);
    chk("acc", 9'h007, acc);
    chk("carry", 9'h001, carry_bit);
    chk("sp", 9'h000, stack_ptr);
    chk("urs", 9'h001, upper_bit_fetch_flag);
    chk("pc", 9'h006, rom_addr);
    $display("test table done");
  endtask
  task t_sea;
    prog({9'h0b4, 9'h025, 9'h0b4, 9'h01c, 9'h100, 9'h01c, 9'h000, 9'h000});
    go(6);
    chk("acc", 9'h00b, acc);
    chk("pc", 9'h006, rom_addr);
    $display("test compare done");
  endtask
  task t_dummy_end;
  endtask
  task results;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    t_moves;
    t_pointer;
    t_ram;
    t_arith;
    t_table;
    t_sea;
    results;
  end
  // the six tests need well under 200 cycles
  initial begin
    #(25 * 2000);
    miscompares++;
    results;
  end
endmodule
